/* logic/lfs_fault_bank.sv */
// Fault status, current-cut control and CRC error count register bank.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Single-short cut bit reduces faulted channel current.
// RULE_02: String-short cut bit reduces shorted channel current.
// RULE_03: String-open cut bit reduces open channel current.
// RULE_04: Twelve per-channel string short flags kept.
// RULE_05: Twelve per-channel string open flags kept.
// RULE_06: Twelve per-channel single LED short flags kept.
// RULE_07: Summary register bit order rolloff to open.
// RULE_08: Rolloff flag set on thermal rolloff.
// RULE_09: Set-pin short flag set on detection.
// RULE_10: Checksum flag set on bad frame.
// RULE_11: Timeout flag set on watchdog expiry.
// RULE_12: Shutdown flag set on thermal shutdown.
// RULE_13: Any-single flag is OR of channels.
// RULE_14: Any-short flag set by any channel.
// RULE_15: Any-open flag set by any channel.
// RULE_16: Fail-safe mode three forces any-open flag.
// RULE_17: CRC counter increments per errored frame.
// RULE_18: CRC counter saturates at all ones.
// RULE_19: Communications reset leaves counter alone.
// RULE_20: Host may write any counter value.
// RULE_21: Host clears count by writing zero.
// RULE_22: Four-bit delay code qualifies fault persistence.
// RULE_23: Flags stick until host writes zero.
module lfs_fault_bank #(
    parameter int LONG_CYC = lfs_pkg::LONG_CYCLES  // Cycles for 0.125 s.
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rstn_i,
    input  wire lfs_pkg::lfs_req_s        req_i,
    input  wire lfs_pkg::lfs_chan_s       chan_i,
    input  wire lfs_pkg::lfs_evt_s        evt_i,
    output logic [7:0]                    rdata_o,
    output logic                          rvalid_o,
    output logic [lfs_pkg::CHANNELS-1:0]  current_cut_o
);

    localparam int CH = lfs_pkg::CHANNELS;
    localparam int DW = lfs_pkg::DELAY_W;

    // Two-stage synchronisers for the asynchronous detector levels.
    lfs_pkg::lfs_chan_s chan_s1_reg, chan_s2_reg;
    lfs_pkg::lfs_evt_s  evt_s1_reg,  evt_s2_reg;

    // Registers visible to the host.
    logic [7:0]    cfg_reg,    cfg_next;      // Cut bits and delay code.
    logic [CH-1:0] short_reg,  short_next;    // Sticky string short flags.
    logic [CH-1:0] open_reg,   open_next;     // Sticky string open flags.
    logic [CH-1:0] single_reg, single_next;   // Sticky single short flags.
    logic [7:0]    kind_reg,   kind_next;     // Fault kind summary.
    logic [7:0]    crc_reg,    crc_next;      // CRC error count.

    // Persistence timers, one per channel and fault type.
    logic [DW-1:0] tmr_reg  [3*CH];
    logic [DW-1:0] tmr_next [3*CH];
    logic [3*CH-1:0] qual;                    // Fault has persisted.

    // Delayed copy of the CRC error level for edge detection.
    logic crc_d_reg;

    // Output registers.
    logic [7:0]    rdata_reg, rdata_next;
    logic          rvalid_reg;
    logic [CH-1:0] cut_reg,   cut_next;

    // Persistence limit in cycles for a delay code.
    function automatic logic [DW-1:0] delay_cycles(input logic [3:0] code);
        logic [DW-1:0] c;
        c = '0;
        if (code < 4'hc) begin
            c = DW'(lfs_pkg::BASE_CYCLES) << code;       // [RULE_22]
        end else begin
            c = DW'(LONG_CYC) << (code - 4'hc);          // [RULE_22]
        end
        return c;
    endfunction : delay_cycles

    // Synchronise detector and event inputs; only stage two reads stage one.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chan_s1_reg <= '0;
            chan_s2_reg <= '0;
            evt_s1_reg  <= '0;
            evt_s2_reg  <= '0;
            crc_d_reg   <= 1'b0;
        end else begin
            chan_s1_reg <= chan_i;
            chan_s2_reg <= chan_s1_reg;
            evt_s1_reg  <= evt_i;
            evt_s2_reg  <= evt_s1_reg;
            crc_d_reg   <= evt_s2_reg.crc_err;
        end
    end

    // Persistence timers count while a raw fault stays present; a glitch
    // shorter than the selected delay never reaches a flag.
    logic [3*CH-1:0] raw;
    assign raw = {chan_s2_reg.single_s, chan_s2_reg.open_s,
                  chan_s2_reg.short_s};

    genvar g;
    generate
        for (g = 0; g < 3*CH; g++) begin : g_tmr
            always_comb begin
                tmr_next[g] = '0;
                qual[g]     = 1'b0;
                if (raw[g]) begin
                    if (tmr_reg[g] >= delay_cycles(cfg_reg[3:0]) - 1'b1) begin
                        tmr_next[g] = tmr_reg[g];
                        qual[g]     = 1'b1;              // [RULE_22]
                    end else begin
                        tmr_next[g] = tmr_reg[g] + 1'b1;
                    end
                end
            end
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    tmr_reg[g] <= '0;
                end else begin
                    tmr_reg[g] <= tmr_next[g];
                end
            end
        end
    endgenerate

    // Register file next values: host writes clear flag bits, hardware flag sets
    // win over a clear arriving in the same cycle; config and count load the write.
    always_comb begin
        logic          wr_cfg, wr_kind, wr_crc;
        logic [CH-1:0] wmask_s, wmask_o, wmask_l;
        logic          crc_evt;
        wr_cfg  = req_i.wr && req_i.addr == lfs_pkg::ADDR_FLT_CONFIG;
        wr_kind = req_i.wr && req_i.addr == lfs_pkg::ADDR_FAULT_KIND;
        wr_crc  = req_i.wr && req_i.addr == lfs_pkg::ADDR_CRC_ERRORS;
        // Only a rising edge of the error level counts as a new error.
        crc_evt = evt_s2_reg.crc_err && !crc_d_reg;
        wmask_s = short_reg;
        wmask_o = open_reg;
        wmask_l = single_reg;
        // Written flag bytes keep only bits written as one.
        if (req_i.wr && req_i.addr == lfs_pkg::ADDR_SHORT_LO)
            wmask_s[5:0]  = short_reg[5:0] & req_i.wdata[5:0];
        if (req_i.wr && req_i.addr == lfs_pkg::ADDR_SHORT_HI)
            wmask_s[11:6] = short_reg[11:6] & req_i.wdata[5:0];
        if (req_i.wr && req_i.addr == lfs_pkg::ADDR_OPEN_LO)
            wmask_o[5:0]  = open_reg[5:0] & req_i.wdata[5:0];
        if (req_i.wr && req_i.addr == lfs_pkg::ADDR_OPEN_HI)
            wmask_o[11:6] = open_reg[11:6] & req_i.wdata[5:0];
        if (req_i.wr && req_i.addr == lfs_pkg::ADDR_SINGLE_LO)
            wmask_l[5:0]  = single_reg[5:0] & req_i.wdata[5:0];
        if (req_i.wr && req_i.addr == lfs_pkg::ADDR_SINGLE_HI)
            wmask_l[11:6] = single_reg[11:6] & req_i.wdata[5:0];
        short_next  = wmask_s | qual[CH-1:0];            // [RULE_04] [RULE_23]
        open_next   = wmask_o | qual[2*CH-1:CH];         // [RULE_05] [RULE_23]
        single_next = wmask_l | qual[3*CH-1:2*CH];       // [RULE_06] [RULE_23]

        cfg_next = wr_cfg ? {1'b0, req_i.wdata[6:0]} : cfg_reg;

        // Summary flags: host write clears, sources set.
        kind_next = wr_kind ? (kind_reg & req_i.wdata) : kind_reg;
        kind_next[lfs_pkg::POS_ROLLOFF]   |= evt_s2_reg.rolloff;     // [RULE_08]
        kind_next[lfs_pkg::POS_CHECKSUM]  |= evt_s2_reg.checksum_fail; // [RULE_10]
        kind_next[lfs_pkg::POS_SET_PIN]   |= evt_s2_reg.set_pin_short; // [RULE_09]
        kind_next[lfs_pkg::POS_COMM_TO]   |= evt_s2_reg.comm_timeout;  // [RULE_11]
        kind_next[lfs_pkg::POS_TSHUT]     |= evt_s2_reg.tshut;       // [RULE_12]
        kind_next[lfs_pkg::POS_ANY_SINGLE] |= |short_or(single_next); // [RULE_13]
        kind_next[lfs_pkg::POS_ANY_SHORT] |= |short_next;            // [RULE_14]
        kind_next[lfs_pkg::POS_ANY_OPEN]  |= |open_next              // [RULE_15]
                                           | evt_s2_reg.failsafe3;   // [RULE_16]

        // CRC counter counts rising edges of the error event and ignores
        // the communications reset; the host write wins over an edge.
        crc_next = crc_reg;
        if (wr_crc) begin
            crc_next = req_i.wdata;                      // [RULE_20] [RULE_21]
        end else if (crc_evt && crc_reg != lfs_pkg::CRC_MAX) begin
            crc_next = crc_reg + 8'h01;                  // [RULE_17] [RULE_18]
        end                                              // [RULE_19]
    end

    // Identity helper kept separate so the OR reduction reads clearly.
    function automatic logic [CH-1:0] short_or(input logic [CH-1:0] v);
        return v;
    endfunction : short_or

    // Read mux and current-cut outputs.
    always_comb begin
        unique case (req_i.addr)
            lfs_pkg::ADDR_FLT_CONFIG: rdata_next = cfg_reg;
            lfs_pkg::ADDR_SHORT_LO:   rdata_next = {2'b00, short_reg[5:0]};
            lfs_pkg::ADDR_SHORT_HI:   rdata_next = {2'b00, short_reg[11:6]};
            lfs_pkg::ADDR_OPEN_LO:    rdata_next = {2'b00, open_reg[5:0]};
            lfs_pkg::ADDR_OPEN_HI:    rdata_next = {2'b00, open_reg[11:6]};
            lfs_pkg::ADDR_SINGLE_LO:  rdata_next = {2'b00, single_reg[5:0]};
            lfs_pkg::ADDR_SINGLE_HI:  rdata_next = {2'b00, single_reg[11:6]};
            lfs_pkg::ADDR_FAULT_KIND: rdata_next = kind_reg;   // [RULE_07]
            lfs_pkg::ADDR_CRC_ERRORS: rdata_next = crc_reg;
            default:                  rdata_next = 8'h00;
        endcase
        // A channel is cut only while its flag is set and its cut bit is on.
        cut_next = ({CH{cfg_reg[lfs_pkg::POS_SINGLE_CUT]}} & single_reg) // [RULE_01]
                 | ({CH{cfg_reg[lfs_pkg::POS_SHORT_CUT]}}  & short_reg)  // [RULE_02]
                 | ({CH{cfg_reg[lfs_pkg::POS_OPEN_CUT]}}   & open_reg);  // [RULE_03]
    end

    // Register state.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_reg    <= lfs_pkg::RST_FLT_CONFIG;
            short_reg  <= '0;
            open_reg   <= '0;
            single_reg <= '0;
            kind_reg   <= lfs_pkg::RST_FAULT_KIND;
            crc_reg    <= lfs_pkg::RST_CRC_ERRORS;
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            cut_reg    <= '0;
        end else begin
            cfg_reg    <= cfg_next;
            short_reg  <= short_next;
            open_reg   <= open_next;
            single_reg <= single_next;
            kind_reg   <= kind_next;
            crc_reg    <= crc_next;
            rdata_reg  <= req_i.rd ? rdata_next : rdata_reg;
            rvalid_reg <= req_i.rd;
            cut_reg    <= cut_next;
        end
    end

    assign rdata_o       = rdata_reg;
    assign rvalid_o      = rvalid_reg;
    assign current_cut_o = cut_reg;

endmodule : lfs_fault_bank

/* logic/lfs_pkg.sv */
// Package holding register map, field layout and timing of the fault bank.
package lfs_pkg;

    // Register offsets on the UART command register port.
    localparam logic [7:0] ADDR_FLT_CONFIG  = 8'h4d;
    localparam logic [7:0] ADDR_SHORT_LO    = 8'h4e;
    localparam logic [7:0] ADDR_SHORT_HI    = 8'h4f;
    localparam logic [7:0] ADDR_OPEN_LO     = 8'h51;
    localparam logic [7:0] ADDR_OPEN_HI     = 8'h52;
    localparam logic [7:0] ADDR_SINGLE_LO   = 8'h54;
    localparam logic [7:0] ADDR_SINGLE_HI   = 8'h55;
    localparam logic [7:0] ADDR_FAULT_KIND  = 8'h57;
    localparam logic [7:0] ADDR_CRC_ERRORS  = 8'h59;

    // Reset values.
    localparam logic [7:0] RST_FLT_CONFIG   = 8'h63;
    localparam logic [7:0] RST_FAULT_KIND   = 8'h00;
    localparam logic [7:0] RST_CRC_ERRORS   = 8'h00;

    // Field positions in the fault configuration register.
    localparam int POS_SHORT_CUT  = 6;
    localparam int POS_OPEN_CUT   = 5;
    localparam int POS_SINGLE_CUT = 4;

    // Bit positions in the fault kind summary register.
    localparam int POS_ROLLOFF    = 7;
    localparam int POS_CHECKSUM   = 6;
    localparam int POS_SET_PIN    = 5;
    localparam int POS_COMM_TO    = 4;
    localparam int POS_TSHUT      = 3;
    localparam int POS_ANY_SINGLE = 2;
    localparam int POS_ANY_SHORT  = 1;
    localparam int POS_ANY_OPEN   = 0;

    // Channel count and half-register width.
    localparam int CHANNELS = 12;
    localparam int HALF     = 6;

    // Saturation value of the CRC error counter.
    localparam logic [7:0] CRC_MAX = 8'hff;

    // Fault report delay: base time and clock rate.
    localparam int BASE_DELAY_NS = 32000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BASE_CYCLES   = BASE_DELAY_NS / CLK_PERIOD_NS;
    // Long codes are 0.125 s upward.
    localparam int LONG_DELAY_NS = 125000000;
    localparam int LONG_CYCLES   = LONG_DELAY_NS / CLK_PERIOD_NS;
    localparam int DELAY_W       = 26;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lfs_req_s;

    // Per-channel raw fault levels from the analog detectors.
    typedef struct packed {
        logic [CHANNELS-1:0] short_s;
        logic [CHANNELS-1:0] open_s;
        logic [CHANNELS-1:0] single_s;
    } lfs_chan_s;

    // Device-wide event and level inputs.
    typedef struct packed {
        logic rolloff;
        logic checksum_fail;
        logic set_pin_short;
        logic comm_timeout;
        logic tshut;
        logic failsafe3;
        logic crc_err;
        logic comm_reset;
    } lfs_evt_s;

endpackage : lfs_pkg

/* testbench/lfs_fault_bank_chk.sv */
// Checker of the fault bank's register port and current-cut outputs.
`timescale 1ns/1ps
module lfs_fault_bank_chk #(
    parameter int LONG_CYC = lfs_pkg::LONG_CYCLES  // Matches the bank.
) (
    input wire logic                    ref_clk_i,
    input wire logic                    rstn_i,
    input wire lfs_pkg::lfs_req_s       req_i,
    input wire lfs_pkg::lfs_chan_s      chan_i,
    input wire lfs_pkg::lfs_evt_s       evt_i,
    input wire logic [7:0]              rdata_o,
    input wire logic                    rvalid_o,
    input wire logic [lfs_pkg::CHANNELS-1:0] current_cut_o
);
    logic [8:0] seen_reg, seen_next;  // Last count read; bit 8 marks it valid.
    logic       crd_reg, crd_next;    // The previous request read the count.
    logic [3:0] fs_reg, fs_next;      // Cycles the fail-safe level stood high.
    wire logic  cw = req_i.wr && req_i.addr == lfs_pkg::ADDR_CRC_ERRORS;
    wire logic  gw = req_i.wr && req_i.addr == lfs_pkg::ADDR_FLT_CONFIG;
    wire logic  gr = req_i.rd && req_i.addr == lfs_pkg::ADDR_FLT_CONFIG;
    // A count write may lower the count, so it restarts the history.
    always_comb begin
        seen_next = cw ? 9'h000 : (rvalid_o && crd_reg) ? {1'b1, rdata_o}
                                                          : seen_reg;
        crd_next = req_i.rd && req_i.addr == lfs_pkg::ADDR_CRC_ERRORS;
        fs_next = evt_i.failsafe3 ? fs_reg + {3'h0, fs_reg != 4'hf} : 4'h0;
    end
    // Helper state only registers the values worked out above.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {seen_reg, crd_reg, fs_reg} <= '0;
        end else begin
            {seen_reg, crd_reg, fs_reg} <= {seen_next, crd_next, fs_next};
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    rd_answer_a: assert property (rvalid_o == $past(req_i.rd))
        else $error("read answer not one cycle after request");
    rdata_hold_a: assert property (!rvalid_o |-> $stable(rdata_o))
        else $error("read data moved without a read");
    reset_clear_a: assert property ($rose(rstn_i) |-> rdata_o == 8'h00
        && !rvalid_o && current_cut_o == '0)
        else $error("outputs not clear after reset");
    crc_write_a: assert property ((cw && !evt_i.crc_err) ##2
        (crd_next && !evt_i.crc_err) |=> rdata_o == $past(req_i.wdata, 3))
        else $error("count differs from value written");
    cfg_write_a: assert property ((gw ##2 gr) |=>
        rdata_o == ($past(req_i.wdata, 3) & 8'h7f))
        else $error("config read differs from value written");
    cut_off_a: assert property ((gw && req_i.wdata[6:4] == 3'h0)
        |=> ##[0:2] current_cut_o == '0)
        else $error("current cut stayed with controls off");
    crc_no_wrap_a: assert property (rvalid_o && crd_reg && seen_reg[8]
        |-> rdata_o >= seen_reg[7:0])
        else $error("count fell without a write");
    failsafe_open_a: assert property ((req_i.rd && fs_reg == 4'hf
        && req_i.addr == lfs_pkg::ADDR_FAULT_KIND)
        |=> rdata_o[lfs_pkg::POS_ANY_OPEN])
        else $error("open flag not forced in fail-safe");
endmodule : lfs_fault_bank_chk
bind lfs_fault_bank lfs_fault_bank_chk #(.LONG_CYC(LONG_CYC)) i_chk (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req_i), .chan_i(chan_i),
    .evt_i(evt_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .current_cut_o(current_cut_o));

/* testbench/lfs_host.sv */
// Host model that issues register requests and collects read answers.
`timescale 1ns/1ps
module lfs_host (
    input  wire logic        ref_clk_i,
    input  wire logic [7:0]  rdata_i,
    input  wire logic        rvalid_i,
    output lfs_pkg::lfs_req_s req_o
);
    initial req_o = '0;
    // One-cycle write; the rising edge in the middle takes it.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] w);
        @(negedge ref_clk_i);
        req_o = {1'b1, 1'b0, a, w};
        @(negedge ref_clk_i);
        req_o = '0;
    endtask : write_reg
    // The answer stands only for the cycle after the request.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] r,
                            output logic v);
        @(negedge ref_clk_i);
        req_o = {1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk_i);
        req_o = '0;
        r = rdata_i;
        v = rvalid_i;
    endtask : read_reg
    // Read the count first so errors counted before the read are kept, then zero it.
    task automatic clear_count(output logic [7:0] r);
        logic v;
        read_reg(lfs_pkg::ADDR_CRC_ERRORS, r, v);
        write_reg(lfs_pkg::ADDR_CRC_ERRORS, 8'h00);
    endtask : clear_count
endmodule : lfs_host

/* testbench/lfs_fault_bank_tb.sv */
// Self-checking bench of the fault bank through its register port.
`timescale 1ns/1ps
module lfs_fault_bank_tb;
    localparam logic [7:0] FK = lfs_pkg::ADDR_FAULT_KIND;
    localparam logic [7:0] CE = lfs_pkg::ADDR_CRC_ERRORS;
    localparam logic [7:0] FC = lfs_pkg::ADDR_FLT_CONFIG;
    logic               ref_clk_i = 1'b0;
    logic               rstn_i    = 1'b0;
    wire lfs_pkg::lfs_req_s req;
    lfs_pkg::lfs_chan_s chan = '0;
    lfs_pkg::lfs_evt_s  evt  = '0;
    wire logic [7:0]    rdata;
    wire logic          rvalid;
    wire logic [11:0]   cut;
    logic [7:0]         d;
    logic               v;
    int miscompares = 0, tests_run = 0, cyc = 0;
    logic [7:0] lo [3] = '{lfs_pkg::ADDR_SHORT_LO, lfs_pkg::ADDR_OPEN_LO,
                           lfs_pkg::ADDR_SINGLE_LO};
    int sb [3] = '{lfs_pkg::POS_ANY_SHORT, lfs_pkg::POS_ANY_OPEN,
                   lfs_pkg::POS_ANY_SINGLE};
    always #10 ref_clk_i = ~ref_clk_i;  // 50 MHz.
    // A short long-delay keeps codes 12 to 15 brief if ever written.
    lfs_fault_bank #(.LONG_CYC(64)) i_dut (.ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i), .req_i(req), .chan_i(chan), .evt_i(evt),
        .rdata_o(rdata), .rvalid_o(rvalid), .current_cut_o(cut));
    lfs_host i_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata),
        .rvalid_i(rvalid), .req_o(req));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic check(input string n, input logic [11:0] s, e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : check
    // Read one register and compare both the strobe and the data.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.read_reg(a, d, v);
        check("read strobe", {11'h0, v}, 12'h001);
        check($sformatf("reg %h", a), {4'h0, d}, {4'h0, e});
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : wt
    // Event inputs are synchronised, so each level holds four cycles.
    task automatic pulse(input int b);
        evt[b] = 1'b1;
        wt(4);
        evt[b] = 1'b0;
        wt(4);
    endtask : pulse
    // A hung run is cut short as a failure.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        wt(16);
        rstn_i = 1'b1;
        rd(FC, lfs_pkg::RST_FLT_CONFIG);
        rd(FK, 8'h00);
        rd(CE, 8'h00);
        rd(8'h50, 8'h00);
        i_host.write_reg(FC, 8'hff);
        rd(FC, 8'h7f);
        i_host.write_reg(FC, 8'h70);
        $display("test reset and config done");
        // Code zero needs 1600 cycles; a shorter fault must not report.
        chan.short_s[0] = 1'b1;
        wt(800);
        chan = '0;
        wt(20);
        rd(lo[0], 8'h00);
        // Channels one and twelve of each kind, then cut and clearing.
        for (int k = 0; k < 3; k++) begin
            chan = 36'h801 << (12 * (2 - k));
            wt(1700);
            chan = '0;
            wt(20);
            rd(lo[k], 8'h01);
            rd(lo[k] + 8'h01, 8'h20);
            rd(FK, 8'h01 << sb[k]);
            check("cut", cut, 12'h801);
            i_host.write_reg(FC, 8'h00);
            wt(4);
            check("cut", cut, 12'h000);
            i_host.write_reg(FC, 8'h70);
            i_host.write_reg(lo[k], 8'h00);
            i_host.write_reg(lo[k] + 8'h01, 8'h00);
            i_host.write_reg(FK, 8'h00);
            wt(4);
            check("cut", cut, 12'h000);
            rd(FK, 8'h00);
        end
        $display("test channel flags done");
        // Event bits 7 to 3 line up with summary bits 7 to 3.
        for (int b = 3; b < 8; b++) begin
            evt = 8'h01 << b;
            wt(1700);
            evt = '0;
            wt(20);
            rd(FK, 8'h01 << b);
            i_host.write_reg(FK, 8'h00);
            rd(FK, 8'h00);
        end
        evt.failsafe3 = 1'b1;
        wt(20);
        rd(FK, 8'h01);
        evt.failsafe3 = 1'b0;
        wt(10);
        rd(FK, 8'h01);
        i_host.write_reg(FK, 8'h00);
        rd(FK, 8'h00);
        $display("test events done");
        repeat (3) pulse(1);
        rd(CE, 8'h03);
        pulse(0);
        rd(CE, 8'h03);
        i_host.write_reg(CE, 8'hfd);
        rd(CE, 8'hfd);
        repeat (4) pulse(1);
        rd(CE, 8'hff);
        i_host.clear_count(d);
        check("count", {4'h0, d}, 12'h0ff);
        rd(CE, 8'h00);
        $display("test error count done");
        report_and_stop();
    end
endmodule : lfs_fault_bank_tb
